// [core/pamux_pin_cell.sv]
// one shared pin: function selection and pad drive
`timescale 1ns/1ps
`default_nettype none
module pamux_pin_cell (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire pamux_pkg::pamux_fn_t reset_fn,
    input  wire pamux_pkg::pamux_fn_t fn_sel,
    input  wire logic               fn_load,
    input  wire logic               pulse_out,
    input  wire logic               serial_drive,
    input  wire logic               serial_out,
    input  wire logic               gpio_out,
    input  wire logic               gpio_dir_out,
    output var  pamux_pkg::pamux_fn_t fn_reg,
    output var  pamux_pkg::pamux_pad_drive_t pad_reg
);
    pamux_pkg::pamux_pad_drive_t pad_next;

    // function register; reset value chosen by variant
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fn_reg <= reset_fn;                                  // R1 R2
        end else if (fn_load) begin
            fn_reg <= fn_sel;                                    // R8
        end
    end

    // only the selected function reaches the pad
    always_comb begin
        pad_next = '{out: 1'b0, oe_n: 1'b1};
        unique case (fn_reg)
            pamux_pkg::PAMUX_FN_NONE: begin
                pad_next = '{out: 1'b0, oe_n: 1'b1};             // R2
            end
            pamux_pkg::PAMUX_FN_PULSE: begin
                pad_next = '{out: pulse_out, oe_n: 1'b0};        // R1
            end
            pamux_pkg::PAMUX_FN_SERIAL: begin
                pad_next = '{out: serial_out, oe_n: ~serial_drive}; // R8
            end
            pamux_pkg::PAMUX_FN_GPIO: begin
                pad_next = '{out: gpio_out, oe_n: ~gpio_dir_out}; // R3
            end
        endcase
    end

    // pad disabled during reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pad_reg <= '{out: 1'b0, oe_n: 1'b1};
        end else begin
            pad_reg <= pad_next;
        end
    end
endmodule : pamux_pin_cell
`default_nettype wire

// [core/pamux_top.sv]
// port a low pin multiplexer: three shared pins
// Overview of operation
// (R1) On the full variant each pin comes out of reset routing its pulse-width channel.
// (R2) On the reduced variant each pin comes out of reset unassigned and undriven.
// (R3) In port mode each pin's direction is set on its own by software.
// (R4) Pin 1 offers the serial port slave select input as an alternate function.
// (R5) Pin 2 offers the serial data line: input in master mode, output in slave mode.
// (R6) As an unselected slave the data-out line is released to high impedance.
// (R7) The slave presents each bit half a serial clock before the master latches it.
// (R8) A per-pin selection picks the function; only it drives the pad.
`timescale 1ns/1ps
`default_nettype none
module pamux_top #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int NUM_PINS     = pamux_pkg::PAMUX_NUM_PINS
) (
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic [1:0]                 fn_sel [NUM_PINS],
    input  wire logic [NUM_PINS-1:0]        fn_load,
    input  wire logic [NUM_PINS-1:0]        motor_pulse_ch,
    input  wire logic [NUM_PINS-1:0]        port_a_out,
    input  wire logic [NUM_PINS-1:0]        port_a_dir_out,
    input  wire pamux_pkg::pamux_serial_out_t serial2_tx,
    input  wire logic [NUM_PINS-1:0]        pad_in,
    output logic      [NUM_PINS-1:0]        pad_out,
    output logic      [NUM_PINS-1:0]        pad_oe_n,
    output logic      [NUM_PINS-1:0]        port_a_in,
    output logic                            serial2_slave_select_n,
    output logic                            serial2_master_data_in,
    output logic      [2*NUM_PINS-1:0]      fn_state
);
    localparam pamux_pkg::pamux_fn_t RESET_FN =
        FULL_VARIANT ? pamux_pkg::PAMUX_FN_RESET_FULL : pamux_pkg::PAMUX_FN_RESET_REDUCED;

    pamux_pkg::pamux_fn_t        fn_cur [NUM_PINS];
    pamux_pkg::pamux_pad_drive_t pad_cur [NUM_PINS];
    logic                        ss_sel;
    logic                        dout_sel;
    logic                        slave_drive;
    logic                        slave_data_reg;

    // one decode shared by the select, data and port input paths
    function automatic logic fn_is(
        input pamux_pkg::pamux_fn_t fn,
        input pamux_pkg::pamux_fn_t code
    );
        return fn == code;
    endfunction : fn_is

    assign ss_sel   = fn_is(fn_cur[pamux_pkg::PAMUX_PIN_SS], pamux_pkg::PAMUX_FN_SERIAL);
    assign dout_sel = fn_is(fn_cur[pamux_pkg::PAMUX_PIN_DOUT], pamux_pkg::PAMUX_FN_SERIAL);

    // drive only as a selected slave; release when deselected
    assign slave_drive = serial2_tx.slave_mode && ss_sel
                         && !serial2_slave_select_n;                  // R5 R6

    // serial block shifts on the leading edge; this stage adds one fixed cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            slave_data_reg <= 1'b0;
        end else begin
            slave_data_reg <= serial2_tx.data;                        // R7
        end
    end

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic [1:0] fn_raw;
        assign fn_raw = fn_sel[i];
        pamux_pin_cell u_cell (
            .sys_clk      (sys_clk),
            .srst         (srst),
            .reset_fn     (RESET_FN),
            .fn_sel       (pamux_pkg::pamux_fn_t'(fn_raw)),
            .fn_load      (fn_load[i]),
            .pulse_out    (motor_pulse_ch[i]),
            .serial_drive ((i == pamux_pkg::PAMUX_PIN_DOUT) ? slave_drive : 1'b0),
            .serial_out   ((i == pamux_pkg::PAMUX_PIN_DOUT) ? slave_data_reg : 1'b0),
            .gpio_out     (port_a_out[i]),
            .gpio_dir_out (port_a_dir_out[i]),
            .fn_reg       (fn_cur[i]),
            .pad_reg      (pad_cur[i])
        );
    end

    // one process drives every bit, so each output variable has a single driver
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pad_out[i]         = pad_cur[i].out;
            pad_oe_n[i]        = pad_cur[i].oe_n;
            fn_state[2*i +: 2] = fn_cur[i];
        end
    end

    // gpio inputs read the pad only when the pin is a port bit
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (srst) begin
                port_a_in[i] <= 1'b0;
            end else begin
                port_a_in[i] <= fn_is(fn_cur[i], pamux_pkg::PAMUX_FN_GPIO) ? pad_in[i] : 1'b0; // R3
            end
        end
    end

    // slave select deasserted unless pin 1 carries it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial2_slave_select_n <= 1'b1;
        end else begin
            serial2_slave_select_n <= ss_sel ? pad_in[pamux_pkg::PAMUX_PIN_SS] : 1'b1; // R4
        end
    end

    // master-mode data input from pin 2
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial2_master_data_in <= 1'b0;
        end else begin
            serial2_master_data_in <= (dout_sel && !serial2_tx.slave_mode)
                                      ? pad_in[pamux_pkg::PAMUX_PIN_DOUT] : 1'b0; // R5
        end
    end
endmodule : pamux_top
`default_nettype wire

// [include/pamux_pkg.sv]
// shared types and constants for the port a low pin multiplexer
`default_nettype none
package pamux_pkg;
    localparam int PAMUX_NUM_PINS = 3;

    // per-pin function code; unassigned is the reduced variant's reset state
    typedef enum logic [1:0] {
        PAMUX_FN_NONE   = 2'h0,
        PAMUX_FN_PULSE  = 2'h1,
        PAMUX_FN_SERIAL = 2'h2,
        PAMUX_FN_GPIO   = 2'h3
    } pamux_fn_t;

    localparam pamux_fn_t PAMUX_FN_RESET_FULL    = PAMUX_FN_PULSE;
    localparam pamux_fn_t PAMUX_FN_RESET_REDUCED = PAMUX_FN_NONE;

    // pin numbers within the group
    localparam int PAMUX_PIN_SS   = 1;
    localparam int PAMUX_PIN_DOUT = 2;

    // one pad: output value, output enable (low = driving)
    typedef struct packed {
        logic out;
        logic oe_n;
    } pamux_pad_drive_t;

    // serial port data-out request from the serial block
    typedef struct packed {
        logic slave_mode;
        logic data;
    } pamux_serial_out_t;
endpackage : pamux_pkg
`default_nettype wire

// [testbench/pamux_board.sv]
// board side of the shared pins: pull-ups and a peer driver
`timescale 1ns/1ps
`default_nettype none
module pamux_board (
    input  wire logic [2:0] pad_out,
    input  wire logic [2:0] pad_oe_n,
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    output logic      [2:0] pad_in
);
    // a released line floats to the pull-up; ext on pin 1 acts as a master's select
    always_comb begin
        for (int i = 0; i < 3; i++) pad_in[i] = !pad_oe_n[i] ? pad_out[i] : !ext_en[i] | ext_val[i];
    end
endmodule : pamux_board
`default_nettype wire

// [testbench/pamux_sva.sv]
// assertions on the shared pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module pamux_sva #(parameter bit FULL_VARIANT = 1'b1, parameter int NUM_PINS = 3) (
    input wire logic                         sys_clk,
    input wire logic                         srst,
    input wire logic [1:0]                   fn_sel [NUM_PINS],
    input wire logic [NUM_PINS-1:0]          fn_load,
    input wire logic [NUM_PINS-1:0]          motor_pulse_ch,
    input wire logic [NUM_PINS-1:0]          port_a_dir_out,
    input wire pamux_pkg::pamux_serial_out_t serial2_tx,
    input wire logic [NUM_PINS-1:0]          pad_in,
    input wire logic [NUM_PINS-1:0]          pad_out,
    input wire logic [NUM_PINS-1:0]          pad_oe_n,
    input wire logic [NUM_PINS-1:0]          port_a_in,
    input wire logic                         serial2_slave_select_n,
    input wire logic                         serial2_master_data_in,
    input wire logic [2*NUM_PINS-1:0]        fn_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_rst; $fell(srst) |-> fn_state == (FULL_VARIANT ? 6'h15 : 6'h00); endproperty
    a_rst: assert property (p_rst) else $error("reset function wrong");
    property p_load; fn_load[0] |=> fn_state[1:0] == $past(fn_sel[0]); endproperty
    a_load: assert property (p_load) else $error("function not loaded");
    property p_pulse; fn_state[1:0] == 2'h1 |=> !pad_oe_n[0] && pad_out[0] == $past(motor_pulse_ch[0]); endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not routed");
    property p_dir; fn_state[3:2] == 2'h3 |=> pad_oe_n[1] == !$past(port_a_dir_out[1]); endproperty
    a_dir: assert property (p_dir) else $error("port direction wrong");
    property p_none; fn_state[1:0] == 2'h0 |=> pad_oe_n[0]; endproperty
    a_none: assert property (p_none) else $error("unassigned pin driven");
    property p_pin; 1'b1 |=> port_a_in[0] == ($past(fn_state[1:0]) == 2'h3 && $past(pad_in[0])); endproperty
    a_pin: assert property (p_pin) else $error("port input wrong");
    property p_ss; 1'b1 |=> serial2_slave_select_n == ($past(fn_state[3:2]) != 2'h2 || $past(pad_in[1])); endproperty
    a_ss: assert property (p_ss) else $error("slave select wrong");
    property p_miso; fn_state[5:4] == 2'h2 && !serial2_tx.slave_mode |=> serial2_master_data_in == $past(pad_in[2]); endproperty
    a_miso: assert property (p_miso) else $error("master data in wrong");
    property p_rel; fn_state[5:4] == 2'h2 |=> pad_oe_n[2] == !$past(serial2_tx.slave_mode && !serial2_slave_select_n); endproperty
    a_rel: assert property (p_rel) else $error("data out enable wrong");
    property p_sdo; fn_state[5:4] == 2'h2 |=> pad_out[2] == $past(serial2_tx.data, 2); endproperty
    a_sdo: assert property (p_sdo) else $error("slave data out wrong");
    c_pulse: cover property (fn_state[1:0] == 2'h1 && motor_pulse_ch[0]);
    c_gpio: cover property (fn_state[3:2] == 2'h3 && port_a_dir_out[1]);
    c_slave: cover property (fn_state[5:4] == 2'h2 && !pad_oe_n[2]);
endmodule : pamux_sva
bind pamux_top pamux_sva #(.FULL_VARIANT(FULL_VARIANT), .NUM_PINS(NUM_PINS)) u_sva (.*);
`default_nettype wire

// [testbench/port_a_low_pin_mux_tb_top.sv]
// self-checking bench for the shared pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module port_a_low_pin_mux_tb_top;
    logic                         sys_clk = 1'b0, srst = 1'b1, sel_n, mdi, msel = 1'b1;
    logic [1:0]                   fn_sel [3];
    logic [2:0]                   fn_load, motor, pout, pdir, ext_en, ext_val, e_oe, e_in;
    logic [2:0]                   pad_in, pad_out, pad_oe_n, port_a_in;
    pamux_pkg::pamux_serial_out_t tx;
    logic [5:0]                   fn_state, red_fn;
    logic [2:0]                   e_out, red_oe;
    logic                         d1 = 1'b0, e_mdi;
    logic [31:0]                  lfsr = 32'h8970;
    int                           num_errors = 0, n_compared = 0, fn [3];
    pamux_top uut (.sys_clk(sys_clk), .srst(srst), .fn_sel(fn_sel), .fn_load(fn_load),
        .motor_pulse_ch(motor), .port_a_out(pout), .port_a_dir_out(pdir), .serial2_tx(tx),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .port_a_in(port_a_in),
        .serial2_slave_select_n(sel_n), .serial2_master_data_in(mdi), .fn_state(fn_state));
    pamux_top #(.FULL_VARIANT(1'b0)) uut_red (.sys_clk(sys_clk), .srst(srst), .fn_sel(fn_sel),
        .fn_load(fn_load), .motor_pulse_ch(motor), .port_a_out(pout), .port_a_dir_out(pdir),
        .serial2_tx(tx), .pad_in(pad_in), .pad_out(), .pad_oe_n(red_oe), .port_a_in(),
        .serial2_slave_select_n(), .serial2_master_data_in(), .fn_state(red_fn));
    pamux_board board (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    always #4 sys_clk = ~sys_clk;
    task automatic check(input string name, input logic [5:0] exp, input logic [5:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    initial begin
        #40000;
        num_errors++;
        give_verdict();
    end
    initial begin
        {fn_load, motor, pout, pdir, ext_en, ext_val, tx} = '0;
        fn_sel = '{default: 2'h0};
        foreach (fn[i]) fn[i] = 1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        check("fn_state", 6'h15, fn_state);
        check("pad_oe_n", 6'h07, pad_oe_n);
        check("red_fn", 6'h00, red_fn);
        // inputs stay idle over this edge, so the model needs no update
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("pad_oe_n", 6'h00, pad_oe_n);
        check("red_oe", 6'h07, red_oe);
        repeat (400) begin
            @(posedge sys_clk);
            // model sees pre-edge values; the design updates in the same edge
            for (int i = 0; i < 3; i++) begin
                e_in[i] = fn[i] == 3 && pad_in[i];
                e_oe[i] = fn[i] == 1 ? 1'b0 : fn[i] == 3 ? !pdir[i] : 1'b1;
                e_out[i] = fn[i] == 1 ? motor[i] : fn[i] == 3 ? pout[i] : (fn[i] == 2 && i == 2) ? d1 : 1'b0;
            end
            e_mdi = fn[2] == 2 && !tx.slave_mode && pad_in[2];
            d1 = tx.data;
            if (fn[2] == 2) e_oe[2] = !(tx.slave_mode && !msel);
            msel = fn[1] != 2 || pad_in[1];
            foreach (fn[i]) if (fn_load[i]) fn[i] = fn_sel[i];
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            {fn_load, motor, pout, pdir, ext_en, ext_val, tx} <= lfsr[19:0];
            fn_sel <= '{lfsr[21:20], lfsr[23:22], lfsr[25:24]};
            @(negedge sys_clk);
            check("fn_state", {fn[2][1:0], fn[1][1:0], fn[0][1:0]}, fn_state);
            check("pad_oe_n", e_oe, pad_oe_n);
            check("port_a_in", e_in, port_a_in);
            check("select_n", msel, sel_n);
            check("pad_out", e_out, pad_out);
            check("master_in", e_mdi, mdi);
        end
        give_verdict();
    end
endmodule : port_a_low_pin_mux_tb_top
`default_nettype wire
